// ### verif/reading_logger_sequencer_tb_top.sv
// Purpose: self-checking bench for the logging sequencer
// Assumes: shortened second and microsecond counts
// Notes:   queues model the session and the persistent store
`timescale 1ns/10ps
module reading_logger_sequencer_tb_top;
  logic mclk_i = 1'b0, srst_i = 1'b1, ext_trig_i = 1'b1;
  logic trig_rise_i = 1'b0, rd_ready_i = 1'b1;
  logic [9:0] pls = '0;
  logic [11:0] delay_s_i = 12'h000;
  logic [31:0] period_us_i = 32'h3, min_per_us_i = 32'h1;
  logic [15:0] pretrig_i = 16'h0000;
  rls_pkg::rls_limit_t limit_i = '0;
  logic meas_req_o, meas_valid_i, rd_valid_o, rd_last_o, cnt_valid_o;
  logic armed_o, logging_o, query_o, save_ask_o, saving_o, done_o;
  rls_pkg::rls_word_t meas_data_i, rd_data_o, disp_data_o;
  logic [15:0] cnt_o, remain_o, taken_o;
  int num_errors = 0, tests_run = 0;
  logic [31:0] sess_q[$], store_q[$];
  rls_top #(.US_CYCLES(2), .S_US(10)) i_dut (.mclk_i, .srst_i,
    .limit_i, .delay_s_i, .period_us_i, .min_per_us_i, .pretrig_i,
    .arm_i(pls[0]), .trig_key_i(pls[1]), .ext_trig_i, .trig_rise_i,
    .any_key_i(pls[2]), .ans_stop_i(pls[3]), .ans_cont_i(pls[4]),
    .ans_save_i(pls[5]), .ans_discard_i(pls[6]), .meas_req_o,
    .meas_valid_i, .meas_data_i, .rd_req_i(pls[7]), .del_req_i(pls[8]),
    .cnt_req_i(pls[9]), .rd_valid_o, .rd_ready_i, .rd_data_o, .rd_last_o,
    .cnt_o, .cnt_valid_o, .disp_data_o, .remain_o, .taken_o, .armed_o,
    .logging_o, .query_o, .save_ask_o, .saving_o, .done_o);
  rls_fe_model i_fe (.mclk_i, .srst_i, .meas_req_i(meas_req_o),
    .meas_valid_o(meas_valid_i), .meas_data_o(meas_data_i));
  // 250 MHz clock
  initial forever #2 mclk_i = ~mclk_i;
  // spacing of readings; one microsecond is two clocks in this bench
  int gap = 0;
  always @(posedge mclk_i)
    if (meas_req_o) begin
      if (gap > 0) check(gap == 2 * (period_us_i < 20 ? 20 : period_us_i),
        "reading spacing");
      gap <= 1;
    end else gap <= (logging_o && gap > 0) ? gap + 1 : 0;
  // every finished reading belongs to the running session
  always @(posedge mclk_i) if (meas_valid_i) sess_q.push_back(meas_data_i);
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic pulse(input int b);
    @(posedge mclk_i) pls[b] <= 1'b1;
    @(posedge mclk_i) pls[b] <= 1'b0;
  endtask
  function automatic logic sel(input int i);
    case (i)
      0: return done_o;
      1: return query_o;
      2: return save_ask_o;
      3: return cnt_valid_o;
      default: return !logging_o && !save_ask_o;
    endcase
  endfunction
  // bounded wait, sampled at the falling edge where outputs are settled
  task automatic wait_sig(input int i, input int lim);
    int t = 0;
    do begin
      @(negedge mclk_i);
      t++;
    end while (sel(i) !== 1'b1 && t < lim);
    if (sel(i) !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: wait %0d ran out", $time, i);
      close_out();
    end
  endtask
  task automatic count_chk();
    pulse(9);
    wait_sig(3, 4);
    check(cnt_o === 16'(store_q.size()), "stored count");
  endtask
  // host stalls at random; the stream must hold each word until taken
  task automatic read_chk();
    int k = 0;
    if (store_q.size() > 0) pulse(7);
    for (int t = 0; t < 2000 && k < store_q.size(); t++) begin
      @(negedge mclk_i);
      if (rd_valid_o === 1'b1 && rd_ready_i) begin
        check(rd_data_o.value === store_q[k], "read word");
        check(rd_last_o === (k == store_q.size() - 1), "last");
        k++;
      end
      @(posedge mclk_i) rd_ready_i <= 1'($urandom_range(0, 1));
    end
    check(k == store_q.size(), "read length");
    @(posedge mclk_i) rd_ready_i <= 1'b1;
  endtask
  // mode 0 runs to the limit, 1 stops and discards, 2 continues
  task automatic session(input int n, input bit ext, input int mode,
                         input bit dur = 1'b0);
    int k;
    int p;
    @(posedge mclk_i);
    p = $urandom_range(20, 24);
    limit_i.count <= 16'(n);
    limit_i.seconds <= 6'(n);
    limit_i.by_duration <= dur;
    period_us_i <= p;
    // ten microseconds to the second in this bench
    if (dur) n = n * 10 / p;
    n = n + pretrig_i;
    sess_q = {};
    pulse(0);
    if (!ext) pulse(1);
    else begin
      @(posedge mclk_i) ext_trig_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      ext_trig_i <= 1'b1;
    end
    if (delay_s_i != 0) begin
      repeat (35) @(posedge mclk_i);
      check(sess_q.size() == 0, "reading before delay");
    end
    if (mode != 0) begin
      repeat (20) @(posedge mclk_i);
      pulse(2);
      wait_sig(1, 10);
      k = sess_q.size();
      repeat (90) @(posedge mclk_i);
      check(sess_q.size() > k, "readings halted");
      pulse(mode == 1 ? 3 : 4);
    end
    if (mode == 1) begin
      wait_sig(2, 10);
      pulse(6);
      wait_sig(4, 20);
    end else begin
      wait_sig(0, 3000);
      check(sess_q.size() == n, "reading total");
      check(remain_o === 16'h0000, "remaining count");
      check(disp_data_o.value === sess_q[$], "shown reading");
      store_q = sess_q;
    end
  endtask
  initial begin
    $urandom(19850);
    repeat (2) @(posedge mclk_i);
    // store count outlives reset, so clear it at power-up, once during reset and once after
    pls[8] <= 1'b1;
    @(posedge mclk_i) srst_i <= 1'b0;
    pls[8] <= 1'b0;
    pulse(8);
    count_chk();
    delay_s_i <= 12'h002;
    session(5, 0, 0);
    delay_s_i <= 12'h000;
    count_chk();
    read_chk();
    session(40, 1, 1);
    count_chk();
    read_chk();
    session(30, 0, 2);
    count_chk();
    read_chk();
    trig_rise_i <= 1'b1;
    session(1, 1, 0);
    count_chk();
    pretrig_i <= 16'h0002;
    session(8, 0, 0, 1'b1);
    count_chk();
    read_chk();
    pulse(8);
    store_q = {};
    count_chk();
    close_out();
  end
endmodule

// ### verif/rls_fe_model.sv
// Purpose: front end model that answers reading requests
// Assumes: one reading at a time, request seen at mclk_i edge
// Notes:   data bus toggles whenever no reading is presented
`timescale 1ns/10ps
module rls_fe_model (
  input  wire logic          mclk_i,       // clock
  input  wire logic          srst_i,       // sync reset
  input  wire logic          meas_req_i,   // start a reading
  output logic               meas_valid_o, // reading done
  output rls_pkg::rls_word_t meas_data_o   // reading value
);
  int   wait_cnt = 0;
  logic busy     = 1'b0;
  logic fin;
  initial meas_valid_o = 1'b0;
  initial meas_data_o = '0;
  assign fin = busy && wait_cnt == 0;
  // random conversion time: prompt and slow answers both occur
  always @(posedge mclk_i) begin
    meas_valid_o <= !srst_i && fin;
    meas_data_o.value <= fin ? $urandom : ~meas_data_o.value; // no stale word
    if (srst_i || fin) begin
      busy <= 1'b0;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 1;
    end else if (meas_req_i) begin
      busy     <= 1'b1;
      wait_cnt <= $urandom_range(0, 5);
    end
  end
endmodule

// ### verilog/rls_consts.svh
// Purpose: constants for the reading logger sequencer
// Assumes: 250 MHz mclk_i, 4 ns period
// Notes:   limits and timing counts as macros
// What this block does
// RULE_01 - store holds at most 50,000 readings
// RULE_02 - stored readings survive power loss
// RULE_03 - first-reading delay programmable 0 to 3600 s
// RULE_04 - readings spaced by programmable sample period
// RULE_05 - limit is reading count or duration
// RULE_06 - count limit programmable 1 to 50,000
// RULE_07 - duration clamped to capacity and 99:59:59
// RULE_08 - armed session starts on key or pulse
// RULE_09 - show each reading and remaining count
// RULE_10 - keep reading until limit unless stopped
// RULE_11 - normal end: saving, write store, complete
// RULE_12 - key raises query, acquisition keeps running
// RULE_13 - confirmed stop asks save or discard
// RULE_14 - confirmed continue keeps original settings
// RULE_15 - pre-trigger readings kept per count
// RULE_16 - remote read returns all stored readings
// RULE_17 - remote delete clears the store; the code ignores a delete request while a remote read is active
// RULE_18 - remote count reports stored readings
// RULE_19 - trigger edge selectable, falling default
// RULE_20 - one trigger buffered during a reading
// RULE_21 - discard leaves store unchanged
`ifndef RLS_CONSTS_SVH
`define RLS_CONSTS_SVH

// ****************************************************************
// capacity and limits
// ****************************************************************
`define RLS_CAPACITY      50000
`define RLS_MAX_DUR_S     359999
`define RLS_MAX_DELAY_S   3600
`define RLS_CLK_MHZ       250
// one microsecond tick: 250 cycles at 250 MHz
`define RLS_US_CYCLES     (`RLS_CLK_MHZ)
// one second in microseconds
`define RLS_S_US          1000000
// least sample period in microseconds
`define RLS_MIN_PER_US    20
`define RLS_MAX_PER_US    32'd3599999990
`define RLS_EDGE_FALL     1'b0

`endif

// ### verilog/rls_pkg.sv
// Purpose: types for the reading logger sequencer
// Assumes: widths fixed by the capacity of the store
// Notes:   used by rls_top and the two bench modules; rls_skid and rls_store do not use it
package rls_pkg;

  // ****************************************************************
  // states and carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    RLS_IDLE, RLS_ARMED, RLS_DELAY, RLS_RUN, RLS_SAVE, RLS_DONE
  } rls_state_t;

  typedef struct packed {
    logic [31:0] value;
  } rls_word_t;

  typedef struct packed {
    logic        by_duration;   // session_limit_kind: 1 duration
    logic [15:0] count;
    logic [6:0]  hours;
    logic [5:0]  minutes;
    logic [5:0]  seconds;
  } rls_limit_t;

endpackage

// ### verilog/rls_skid.sv
// Purpose: two-entry buffer in the reading path
// Assumes: standard valid/ready on both sides
// Notes:   full ready is registered-independent of out_ready_i
`timescale 1ns/10ps
module rls_skid #(
  parameter int W = 32
) (
  input  wire logic         mclk_i,      // clock
  input  wire logic         srst_i,      // sync reset
  input  wire logic         in_valid_i,  // word offered
  output logic              in_ready_o,  // room left
  input  wire logic [W-1:0] in_data_i,   // word in
  output logic              out_valid_o, // word held
  input  wire logic         out_ready_i, // consumer takes
  output logic      [W-1:0] out_data_o   // word out
);
  initial begin
    if (W < 1) $error("rls_skid: width must be positive");
  end

  logic [W-1:0] mem_reg [2];
  logic         rd_reg;
  logic         wr_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  // handshakes: stall reaches the source through in_ready_o
  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_reg];

  // storage and pointers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_reg  <= 1'b0;
      wr_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wr_reg] <= in_data_i;
        wr_reg <= ~wr_reg;
      end
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### verilog/rls_store.sv
// Purpose: reading store with commit and discard
// Assumes: array stands for the persistent_reading_store
// Notes:   session words go to a staging area until commit
`timescale 1ns/10ps
`include "rls_consts.svh"
module rls_store #(
  parameter int DEPTH = `RLS_CAPACITY,
  parameter int AW    = 16
) (
  input  wire logic          mclk_i,    // clock
  input  wire logic          srst_i,    // sync reset
  input  wire logic          wr_i,      // stage a reading
  input  wire logic [31:0]   wdata_i,   // reading
  input  wire logic          commit_i,  // make staged persistent
  input  wire logic          discard_i, // drop staged
  input  wire logic          clear_i,   // delete all
  input  wire logic [AW-1:0] raddr_i,   // read index
  output logic      [31:0]   rdata_o,   // read data
  output logic      [AW-1:0] stored_o,  // persistent count
  output logic      [AW-1:0] staged_o   // staged count
);
  initial begin
    if (DEPTH < 1 || DEPTH >= (1 << AW)) $error("rls_store: depth");
  end

  logic [31:0]   mem [2][DEPTH];
  logic          bank_reg;
  logic [AW-1:0] stored_reg;
  logic [AW-1:0] staged_reg;

  // staging fills the bank not in use, so a discard never touches
  // the committed readings; writes beyond capacity are dropped
  always_ff @(posedge mclk_i) begin
    if (wr_i && staged_reg < AW'(DEPTH))
      mem[!bank_reg][staged_reg] <= wdata_i;                     // RULE_01
    rdata_o <= mem[bank_reg][raddr_i];
  end

  // commit loads the persistent count and swaps the bank in use;
  // reset does not clear it, so stored words outlive power loss
  always_ff @(posedge mclk_i) begin
    if (clear_i) begin
      stored_reg <= '0;                                          // RULE_17
      bank_reg   <= 1'b0;
    end else if (commit_i) begin
      stored_reg <= staged_reg;                                  // RULE_02
      bank_reg   <= !bank_reg;                                   // RULE_21
    end
  end

  // staging counter
  always_ff @(posedge mclk_i) begin
    if (srst_i || discard_i || commit_i || clear_i)
      staged_reg <= '0;                                          // RULE_21
    else if (wr_i && staged_reg < AW'(DEPTH))
      staged_reg <= staged_reg + 1'b1;
  end

  assign stored_o = stored_reg;
  assign staged_o = staged_reg;
endmodule

// ### verilog/rls_top.sv
// Purpose: sequencer for a reading-logging session
// Assumes: readings arrive on a valid strobe from the front end
// Notes:   times counted in microsecond ticks of mclk_i
`timescale 1ns/10ps
`include "rls_consts.svh"
module rls_top #(
  parameter int US_CYCLES = `RLS_US_CYCLES,
  parameter int S_US      = `RLS_S_US,
  parameter int DEPTH     = `RLS_CAPACITY
) (
  input  wire logic              mclk_i,        // 250 MHz clock
  input  wire logic              srst_i,        // sync reset
  input  wire rls_pkg::rls_limit_t limit_i,     // session limit
  input  wire logic [11:0]       delay_s_i,     // first delay s
  input  wire logic [31:0]       period_us_i,   // sample period us
  input  wire logic [31:0]       min_per_us_i,  // config least period
  input  wire logic [15:0]       pretrig_i,     // pre-trigger count
  input  wire logic              arm_i,         // setup entered
  input  wire logic              trig_key_i,    // trigger key pulse
  input  wire logic              ext_trig_i,    // external trigger pin
  input  wire logic              trig_rise_i,   // 1 rising edge
  input  wire logic              any_key_i,     // key during session
  input  wire logic              ans_stop_i,    // query answer stop
  input  wire logic              ans_cont_i,    // query answer continue
  input  wire logic              ans_save_i,    // save collected
  input  wire logic              ans_discard_i, // discard collected
  output logic                   meas_req_o,    // start a reading
  input  wire logic              meas_valid_i,  // reading done
  input  wire rls_pkg::rls_word_t meas_data_i,  // reading value
  input  wire logic              rd_req_i,      // remote read all
  input  wire logic              del_req_i,     // remote delete
  input  wire logic              cnt_req_i,     // remote count
  output logic                   rd_valid_o,    // read word valid
  input  wire logic              rd_ready_i,    // host takes word
  output rls_pkg::rls_word_t     rd_data_o,     // read word
  output logic                   rd_last_o,     // last word of read
  output logic [15:0]            cnt_o,         // stored count
  output logic                   cnt_valid_o,   // count answer
  output rls_pkg::rls_word_t     disp_data_o,   // latest reading
  output logic [15:0]            remain_o,      // readings left
  output logic [15:0]            taken_o,       // progress
  output logic                   armed_o,       // waiting trigger
  output logic                   logging_o,     // session running
  output logic                   query_o,       // continue or stop?
  output logic                   save_ask_o,    // save or discard?
  output logic                   saving_o,      // saving readings
  output logic                   done_o         // logging complete
);
  initial begin
    if (US_CYCLES < 1 || US_CYCLES > 512 || S_US < 1)
      $error("rls_top: tick counts");
    if (DEPTH < 1 || DEPTH > 65535) $error("rls_top: depth");
  end

  // ****************************************************************
  // state and timing
  // ****************************************************************
  rls_pkg::rls_state_t state_reg;
  logic [8:0]   tick_cnt_reg;
  logic         tick;
  logic [31:0]  per_cnt_reg;
  logic [31:0]  sec_cnt_reg;
  logic [11:0]  dly_s_reg;
  logic [15:0]  remain_reg;
  logic [15:0]  target;
  logic         ext_d_reg;
  logic         ext_edge;
  logic         trig_pend_reg;
  logic         busy_reg;
  logic         query_reg;
  logic         ask_reg;
  logic         sample;
  logic [31:0]  eff_per;
  logic [31:0]  dur_s;
  logic [31:0]  dur_n;
  logic [63:0]  dur_q;
  logic         wr;
  logic         commit;
  logic         discard;
  logic [15:0]  stored;
  logic [15:0]  staged;
  logic [31:0]  mem_rdata;
  logic [15:0]  raddr_reg;
  logic         rd_act_reg;
  logic         rd_fill_reg;
  logic [15:0]  rd_idx_reg;
  logic         buf_in_ready;
  logic         buf_out_valid;
  logic [32:0]  buf_out;

  // reading count capped at the store capacity DEPTH
  function automatic logic [15:0] clamp16(input logic [31:0] n);
    clamp16 = (n > 32'(DEPTH)) ? 16'(DEPTH) : n[15:0];
  endfunction

  // microsecond tick
  assign tick = (tick_cnt_reg == 9'(US_CYCLES - 1));
  always_ff @(posedge mclk_i) begin
    if (srst_i || tick) tick_cnt_reg <= 9'h000;
    else tick_cnt_reg <= tick_cnt_reg + 9'h001;
  end

  // duration converted to readings, never above 99:59:59
  always_comb begin
    dur_s = 32'(limit_i.hours) * 32'd3600 + 32'(limit_i.minutes) * 32'd60
          + 32'(limit_i.seconds);
    if (dur_s > `RLS_MAX_DUR_S) dur_s = `RLS_MAX_DUR_S;           // RULE_07
    eff_per = (period_us_i < min_per_us_i) ? min_per_us_i : period_us_i;
    if (eff_per > `RLS_MAX_PER_US) eff_per = `RLS_MAX_PER_US;     // RULE_04
    if (eff_per < `RLS_MIN_PER_US) eff_per = `RLS_MIN_PER_US;
    // wide product: a full 99:59:59 in microseconds overflows 32 bits
    dur_q = (64'(dur_s) * 64'(S_US)) / 64'(eff_per);
    dur_n = (dur_q > 64'(DEPTH)) ? 32'(DEPTH) : dur_q[31:0];
    if (dur_n == 32'h0) dur_n = 32'h1;
  end
  // one limit kind applies; count kept inside 1..capacity
  assign target = limit_i.by_duration ? clamp16(dur_n)           // RULE_05
                : (limit_i.count == 16'h0000 ? 16'h0001          // RULE_06
                : clamp16(32'(limit_i.count)));

  // trigger edge select, falling by default when trig_rise_i low
  always_ff @(posedge mclk_i) begin
    if (srst_i) ext_d_reg <= 1'b1;
    else ext_d_reg <= ext_trig_i;
  end
  assign ext_edge = (trig_rise_i != `RLS_EDGE_FALL)              // RULE_19
                  ? (ext_trig_i && !ext_d_reg)
                  : (!ext_trig_i && ext_d_reg);

  // one trigger held while a reading is in progress
  always_ff @(posedge mclk_i) begin
    if (srst_i) trig_pend_reg <= 1'b0;
    else if (ext_edge && busy_reg) trig_pend_reg <= 1'b1;        // RULE_20
    else if (!busy_reg) trig_pend_reg <= 1'b0;
  end

  // ****************************************************************
  // session sequence
  // ****************************************************************
  assign sample = (state_reg == rls_pkg::RLS_RUN) && tick
               && (per_cnt_reg == 32'h0) && !busy_reg;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_reg <= rls_pkg::RLS_IDLE;
    end else begin
      case (state_reg)
        rls_pkg::RLS_IDLE:  if (arm_i) state_reg <= rls_pkg::RLS_ARMED;
        rls_pkg::RLS_ARMED:
          if (trig_key_i || ext_edge || trig_pend_reg)              // RULE_08
            state_reg <= (delay_s_i == 12'h000) ? rls_pkg::RLS_RUN
                                                : rls_pkg::RLS_DELAY;
        rls_pkg::RLS_DELAY:
          if (tick && sec_cnt_reg == 32'h0 && dly_s_reg <= 12'h001) // RULE_03
            state_reg <= rls_pkg::RLS_RUN;
        rls_pkg::RLS_RUN: begin
          if (ask_reg && ans_save_i) state_reg <= rls_pkg::RLS_SAVE; // RULE_13
          else if (ask_reg && ans_discard_i)
            state_reg <= rls_pkg::RLS_DONE;                         // RULE_21
          else if (remain_reg == 16'h0000 && !busy_reg)
            state_reg <= rls_pkg::RLS_SAVE;                         // RULE_10
        end
        rls_pkg::RLS_SAVE:  state_reg <= rls_pkg::RLS_DONE;         // RULE_11
        rls_pkg::RLS_DONE:  if (arm_i) state_reg <= rls_pkg::RLS_ARMED;
        default:            state_reg <= rls_pkg::RLS_IDLE;
      endcase
    end
  end

  // first-reading delay in seconds, counted in microsecond ticks
  always_ff @(posedge mclk_i) begin
    if (srst_i || state_reg == rls_pkg::RLS_ARMED) begin
      dly_s_reg   <= (delay_s_i > 12'(`RLS_MAX_DELAY_S))
                   ? 12'(`RLS_MAX_DELAY_S) : delay_s_i;
      sec_cnt_reg <= 32'(S_US - 1);
    end else if (state_reg == rls_pkg::RLS_DELAY && tick) begin
      if (sec_cnt_reg == 32'h0) begin
        sec_cnt_reg <= 32'(S_US - 1);
        dly_s_reg   <= dly_s_reg - 12'h001;
      end else begin
        sec_cnt_reg <= sec_cnt_reg - 32'h1;
      end
    end
  end

  // sample period counter; first reading on entry to run
  always_ff @(posedge mclk_i) begin
    if (srst_i || state_reg != rls_pkg::RLS_RUN) per_cnt_reg <= 32'h0;
    else if (sample) per_cnt_reg <= eff_per - 32'h1;               // RULE_04
    else if (tick && per_cnt_reg != 32'h0)
      per_cnt_reg <= per_cnt_reg - 32'h1;
  end

  // reading request and busy window; query does not pause it
  assign meas_req_o = sample && remain_reg != 16'h0000 && buf_in_ready;
  always_ff @(posedge mclk_i) begin
    if (srst_i) busy_reg <= 1'b0;
    else if (meas_req_o) busy_reg <= 1'b1;                         // RULE_12
    else if (meas_valid_i) busy_reg <= 1'b0;
  end

  // remaining count; pre-trigger readings counted on top
  always_ff @(posedge mclk_i) begin
    if (srst_i) remain_reg <= 16'h0000;
    else if (state_reg == rls_pkg::RLS_ARMED)
      remain_reg <= clamp16(32'(target) + 32'(pretrig_i));          // RULE_15
    else if (meas_req_o) remain_reg <= remain_reg - 16'h0001;       // RULE_09
  end

  // continue/stop query, then save/discard question
  always_ff @(posedge mclk_i) begin
    if (srst_i || state_reg != rls_pkg::RLS_RUN) begin
      query_reg <= 1'b0;
      ask_reg   <= 1'b0;
    end else if (query_reg && ans_cont_i) begin
      query_reg <= 1'b0;                                            // RULE_14
    end else if (query_reg && ans_stop_i) begin
      query_reg <= 1'b0;
      ask_reg   <= 1'b1;                                            // RULE_13
    end else if (any_key_i && !ask_reg) begin
      query_reg <= 1'b1;                                            // RULE_12
    end
  end

  // latest reading for display
  always_ff @(posedge mclk_i) begin
    if (srst_i) disp_data_o <= '0;
    else if (meas_valid_i && busy_reg) disp_data_o <= meas_data_i;  // RULE_09
  end

  // ****************************************************************
  // store and remote requests
  // ****************************************************************
  assign wr      = meas_valid_i && busy_reg && state_reg == rls_pkg::RLS_RUN;
  assign commit  = (state_reg == rls_pkg::RLS_SAVE);                // RULE_11
  assign discard = (state_reg == rls_pkg::RLS_RUN) && ask_reg
                && ans_discard_i;                                   // RULE_21

  rls_store #(.DEPTH(DEPTH), .AW(16)) u_store (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .wr_i      (wr),
    .wdata_i   (meas_data_i.value),
    .commit_i  (commit),
    .discard_i (discard || state_reg == rls_pkg::RLS_ARMED),
    .clear_i   (del_req_i && !rd_act_reg),                          // RULE_17
    .raddr_i   (raddr_reg),
    .rdata_o   (mem_rdata),
    .stored_o  (stored),
    .staged_o  (staged)
  );

  // remote read walks every stored word into the buffer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_act_reg  <= 1'b0;
      rd_fill_reg <= 1'b0;
      raddr_reg   <= 16'h0000;
      rd_idx_reg  <= 16'h0000;
    end else if (!rd_act_reg) begin
      rd_fill_reg <= 1'b0;
      raddr_reg   <= 16'h0000;
      rd_idx_reg  <= 16'h0000;
      if (rd_req_i && stored != 16'h0000) rd_act_reg <= 1'b1;      // RULE_16
    end else if (!rd_fill_reg) begin
      rd_fill_reg <= 1'b1;
    end else if (buf_in_ready) begin
      rd_idx_reg  <= rd_idx_reg + 16'h0001;
      raddr_reg   <= rd_idx_reg + 16'h0001;
      rd_fill_reg <= 1'b0;
      if (rd_idx_reg + 16'h0001 == stored) rd_act_reg <= 1'b0;
    end
  end

  rls_skid #(.W(33)) u_buf (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (rd_act_reg && rd_fill_reg),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({rd_idx_reg + 16'h0001 == stored, mem_rdata}),
    .out_valid_o (buf_out_valid),
    .out_ready_i (rd_ready_i),
    .out_data_o  (buf_out)
  );
  assign rd_valid_o = buf_out_valid;
  assign rd_data_o  = buf_out[31:0];
  assign rd_last_o  = buf_out[32];

  // count answer one cycle after request
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_o       <= 16'h0000;
      cnt_valid_o <= 1'b0;
    end else begin
      cnt_valid_o <= cnt_req_i;                                     // RULE_18
      if (cnt_req_i) cnt_o <= stored;
    end
  end

  // status outputs
  assign remain_o   = remain_reg;
  assign taken_o    = staged;
  assign armed_o    = (state_reg == rls_pkg::RLS_ARMED);
  assign logging_o  = (state_reg == rls_pkg::RLS_RUN);
  assign query_o    = query_reg;
  assign save_ask_o = ask_reg;
  assign saving_o   = (state_reg == rls_pkg::RLS_SAVE);
  assign done_o     = (state_reg == rls_pkg::RLS_DONE);

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_stop_asked;
    query_reg && ans_stop_i;
  endsequence

  a_count_cap: assert property (@(posedge mclk_i) disable iff (srst_i)
    staged <= 16'(DEPTH)) else $error("staging above capacity"); // RULE_01
  a_stored_keep: assert property (@(posedge mclk_i) disable iff (srst_i)
    !commit && !del_req_i |=> $stable(stored) || $past(del_req_i))
    else $error("stored count moved"); // RULE_02
  a_arm_start: assert property (@(posedge mclk_i) disable iff (srst_i)
    armed_o && trig_key_i |=> !armed_o) else $error("no start"); // RULE_08
  a_edge_fall: assert property (@(posedge mclk_i) disable iff (srst_i)
    !trig_rise_i && $fell(ext_trig_i) |-> ext_edge)
    else $error("falling edge missed"); // RULE_19
  a_remain_dec: assert property (@(posedge mclk_i) disable iff (srst_i)
    meas_req_o |=> remain_reg == $past(remain_reg) - 16'h0001)
    else $error("remaining count off"); // RULE_09
  a_save_done: assert property (@(posedge mclk_i) disable iff (srst_i)
    saving_o |=> done_o && stored == $past(staged))
    else $error("save sequence wrong"); // RULE_11
  a_query_run: assert property (@(posedge mclk_i) disable iff (srst_i)
    query_reg && logging_o |=> logging_o || saving_o || done_o)
    else $error("query halted logging"); // RULE_12
  a_stop_ask: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_stop_asked |=> save_ask_o || !logging_o)
    else $error("stop did not ask"); // RULE_13
  a_discard_keep: assert property (@(posedge mclk_i) disable iff (srst_i)
    discard && !del_req_i |=> stored == $past(stored))
    else $error("discard changed store"); // RULE_21
  a_count_ans: assert property (@(posedge mclk_i) disable iff (srst_i)
    cnt_req_i |=> cnt_valid_o && cnt_o == $past(stored))
    else $error("count answer wrong"); // RULE_18
endmodule
